/* File: verilog/mmd_pkg.sv */
// mmd_pkg: address map, timing counts and route codes of the memory map decoder
// assumes: byte addresses from a 32-bit requester, one 125 MHz clock
package mmd_pkg;
	// memory regions (byte addresses, tops exclusive)
	localparam logic [31:0] ALIAS_TOP     = 32'h0002_0000; // window at address zero
	localparam logic [31:0] SRAM_BASE     = 32'h0004_0000; // own home of sram
	localparam logic [31:0] SRAM_BYTES    = 32'h0000_2000; // 2k words of 32 bits
	localparam logic [31:0] FLASH1_BASE   = 32'h0008_0000;
	localparam logic [31:0] FLASH0_BASE   = 32'h0009_0000;
	localparam logic [31:0] FLASH0_USER   = 32'h0009_f700; // boot page above this
	localparam logic [31:0] FLASH_TOP     = 32'h000a_0000;
	localparam logic [16:0] BOOT_OFF      = 17'h1_f700;    // boot page, offset from bank 1
	// peripheral register space
	localparam logic [31:0] PER_BASE      = 32'hffff_0000; // interrupt block is lowest
	localparam logic [31:0] SYSCTL_BASE   = 32'hffff_0200;
	localparam logic [31:0] REMAP_ADDR    = 32'hffff_0220;
	localparam int          GRAN_LSB      = 7;             // 128-byte occupancy granules
	localparam logic [31:0] OCC_MAP       = 32'hb457_0fd7; // occupied granules
	localparam logic [31:0] AHB_MAP       = 32'h3400_0000; // gpio and flash control
	localparam logic        REMAP_RST     = 1'h1;          // flash at zero after reset
	localparam int          REMAP_BIT     = 0;
	// flash and sram geometry
	localparam int          PAGE_BYTES    = 512;
	localparam int          PAGE_HW_LSB   = 8;             // page index in halfword address
	localparam int          FLASH_HW_W    = 15;            // 32k halfwords per bank
	localparam int          SRAM_AW       = 11;
	// timing
	localparam int          CLK_PS        = 8000;
	localparam int          CPU_KHZ       = 41780;
	localparam int          FLASH_MAX_PS  = 1_000_000_000 / CPU_KHZ;
	localparam int          FLASH_MAX_CYC = FLASH_MAX_PS / CLK_PS; // longest, rounds down
	localparam int          AHB_CYC       = 1;
	localparam int          APB_CYC       = 2;
	// access sizes
	localparam logic [1:0]  SZ_BYTE       = 2'h0;
	localparam logic [1:0]  SZ_HALF       = 2'h1;
	localparam logic [1:0]  SZ_WORD       = 2'h2;
	typedef enum logic [2:0] {
		RT_HOLE, RT_SRAM, RT_FLASH, RT_AHB, RT_APB, RT_REMAP, RT_PHOLE
	} mmd_route_t;
endpackage

/* File: verilog/mmd_dec_if.sv */
// mmd_dec_if: request address in, decoded route and offset out
// assumes: purely combinational use inside one clock domain
`timescale 1ns/1ps
`default_nettype none
interface mmd_dec_if;
	logic [31:0]        addr;  // requested byte address
	logic               remap; // 1 places flash at zero
	logic               write; // write request
	mmd_pkg::mmd_route_t route;
	logic [16:0]        off;   // offset within target
	modport req (output addr, remap, write, input route, off);
	modport dec (input addr, remap, write, output route, off);
endinterface
`default_nettype wire

/* File: verilog/mmd_region_dec.sv */
// mmd_region_dec: maps a byte address onto a target and its local offset
// assumes: address held stable by the caller for the cycle of the decision
`timescale 1ns/1ps
`default_nettype none
module mmd_region_dec (
	mmd_dec_if.dec dif
);
	logic [31:0] a;
	logic [4:0]  gran;
	localparam int GRAN_LSB_HI = mmd_pkg::GRAN_LSB + 4; // top bit of the granule index
	assign a    = dif.addr;
	assign gran = a[GRAN_LSB_HI:mmd_pkg::GRAN_LSB];

	// address compare chain, first match wins
	always_comb begin
		dif.route = mmd_pkg::RT_HOLE;
		dif.off   = a[16:0];
		if (a < mmd_pkg::ALIAS_TOP) begin
			if (dif.remap) begin
				dif.route = mmd_pkg::RT_FLASH;
				// boot page stays read only through the alias too
				if (dif.write && a[16:0] >= mmd_pkg::BOOT_OFF)
					dif.route = mmd_pkg::RT_HOLE;
			end else if (a < mmd_pkg::SRAM_BYTES) begin
				dif.route = mmd_pkg::RT_SRAM;
			end
		end else if (a >= mmd_pkg::SRAM_BASE && a < mmd_pkg::SRAM_BASE + mmd_pkg::SRAM_BYTES) begin
			dif.route = mmd_pkg::RT_SRAM;
			dif.off   = 17'(a - mmd_pkg::SRAM_BASE);
		end else if (a >= mmd_pkg::FLASH1_BASE && a < mmd_pkg::FLASH_TOP) begin
			dif.route = mmd_pkg::RT_FLASH;
			dif.off   = 17'(a - mmd_pkg::FLASH1_BASE);
			if (dif.write && a >= mmd_pkg::FLASH0_USER)
				dif.route = mmd_pkg::RT_HOLE;
		end else if (a >= mmd_pkg::PER_BASE) begin
			dif.off   = {1'h0, a[15:0]};
			if (a[15:12] != 4'h0 || !mmd_pkg::OCC_MAP[gran])
				dif.route = mmd_pkg::RT_PHOLE;
			else if (a[31:2] == mmd_pkg::REMAP_ADDR[31:2])
				dif.route = mmd_pkg::RT_REMAP;
			else if (mmd_pkg::AHB_MAP[gran])
				dif.route = mmd_pkg::RT_AHB;
			else
				dif.route = mmd_pkg::RT_APB;
		end
	end
endmodule // mmd_region_dec
`default_nettype wire

/* File: verilog/mmd_memory_map_decoder.sv */
// mmd_memory_map_decoder: routes requester accesses to flash, sram and register buses
// assumes: requester and targets share clk_sys_in; targets answer read data
// combinationally while their select is high
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - flash appears at address zero after reset
// - clearing remap bit 0 puts sram at zero
// - little endian byte lanes everywhere
// - bank 0 at 0x90000, boot page protected
// - bank 1 at 0x80000, all user space
// - flash pages are 512 bytes
// - word from flash is two halfword accesses
// - halfword flash access fast enough for cpu
// - sram 2k words, single full-width access
// - registers in the top address pages
// - fast bus one cycle, slow bus two
// - flash control and gpio on fast bus
// - interrupt block at 0xffff0000
// - system control block at 0xffff0200
module mmd_memory_map_decoder (
	input  wire logic        clk_sys_in,
	input  wire logic        rst_b_in,
	input  wire logic        ce_in,
	input  wire logic        req_valid_in,
	input  wire logic [31:0] req_addr_in,
	input  wire logic        req_write_in,
	input  wire logic [1:0]  req_size_in,
	input  wire logic [31:0] req_wdata_in,
	output logic             req_ready_out,
	output logic             rsp_ack_out,
	output logic             rsp_err_out,
	output logic [31:0]      rsp_rdata_out,
	output logic             remap_out,
	output logic             flash_sel_out,
	output logic             flash_bank_out,
	output logic [14:0]      flash_haddr_out,
	output logic [6:0]       flash_page_out,
	output logic [1:0]       flash_be_out,
	output logic [15:0]      flash_wdata_out,
	input  wire logic [15:0] flash_rdata_in,
	output logic             sram_sel_out,
	output logic [10:0]      sram_addr_out,
	input  wire logic [31:0] sram_rdata_in,
	output logic             ahb_sel_out,
	output logic             apb_sel_out,
	output logic [15:0]      per_addr_out,
	input  wire logic [31:0] ahb_rdata_in,
	input  wire logic [31:0] apb_rdata_in,
	output logic             tgt_write_out,
	output logic [3:0]       tgt_be_out,
	output logic [31:0]      tgt_wdata_out
);
	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_FLASH_HI} mmd_state_t;

	mmd_dec_if dif ();
	mmd_region_dec u_dec (.dif(dif));

	mmd_state_t          state_reg, state_next;       // access sequencer
	logic                cnt_reg, cnt_next;           // extra wait for slow bus
	mmd_pkg::mmd_route_t route_reg, route_next;       // target of open access
	logic                word_reg, word_next;         // full word access
	logic [15:0]         lo_reg, lo_next;             // low flash half of a word
	logic                remap_reg, remap_next;
	logic                ready_reg, ready_next;
	logic                ack_reg, ack_next;
	logic                err_reg, err_next;
	logic [31:0]         rdata_reg, rdata_next;
	logic                fsel_reg, fsel_next;
	logic                fbank_reg, fbank_next;
	logic [14:0]         fhaddr_reg, fhaddr_next;
	logic [1:0]          fbe_reg, fbe_next;
	logic [15:0]         fwdata_reg, fwdata_next;
	logic                ssel_reg, ssel_next;
	logic [10:0]         saddr_reg, saddr_next;
	logic                ahb_reg, ahb_next;
	logic                apb_reg, apb_next;
	logic [15:0]         paddr_reg, paddr_next;
	logic                write_reg, write_next;
	logic [3:0]          be_reg, be_next;
	logic [31:0]         wdata_reg, wdata_next;
	logic [3:0]          be_w;                        // lanes of the new request
	logic                take_w;                      // request accepted this edge

	// byte lanes follow the low address bits: lowest address, lowest lane
	function automatic logic [3:0] lane_be(input logic [1:0] sz, input logic [1:0] a);
		case (sz)
			mmd_pkg::SZ_BYTE: lane_be = 4'h1 << a;
			mmd_pkg::SZ_HALF: lane_be = a[1] ? 4'hc : 4'h3;
			default:          lane_be = 4'hf;
		endcase
	endfunction

	assign dif.addr  = req_addr_in;
	assign dif.remap = remap_reg;
	assign dif.write = req_write_in;
	assign be_w      = lane_be(req_size_in, req_addr_in[1:0]);
	assign take_w    = ce_in && ready_reg && req_valid_in;

	// next state of the sequencer and every registered output
	always_comb begin
		state_next  = state_reg;
		cnt_next    = cnt_reg;
		route_next  = route_reg;
		word_next   = word_reg;
		lo_next     = lo_reg;
		remap_next  = remap_reg;
		ready_next  = ready_reg;
		ack_next    = 1'h0;
		err_next    = 1'h0;
		rdata_next  = rdata_reg;
		fsel_next   = fsel_reg;
		fbank_next  = fbank_reg;
		fhaddr_next = fhaddr_reg;
		fbe_next    = fbe_reg;
		fwdata_next = fwdata_reg;
		ssel_next   = ssel_reg;
		saddr_next  = saddr_reg;
		ahb_next    = ahb_reg;
		apb_next    = apb_reg;
		paddr_next  = paddr_reg;
		write_next  = write_reg;
		be_next     = be_reg;
		wdata_next  = wdata_reg;
		case (state_reg)
			ST_IDLE: begin
				if (req_valid_in) begin
					route_next = dif.route;
					write_next = req_write_in;
					be_next    = be_w;
					wdata_next = req_wdata_in;
					word_next  = req_size_in == mmd_pkg::SZ_WORD;
					ready_next = 1'h0;
					state_next = ST_WAIT;
					cnt_next   = 1'h0;
					paddr_next = req_addr_in[15:0];
					case (dif.route)
						mmd_pkg::RT_SRAM: begin
							ssel_next  = 1'h1;
							saddr_next = dif.off[12:2];
						end
						mmd_pkg::RT_FLASH: begin
							fsel_next  = 1'h1;
							fbank_next = ~dif.off[16];
							if (req_size_in == mmd_pkg::SZ_WORD) begin
								// low half first, high half next cycle
								fhaddr_next = {dif.off[15:2], 1'h0};
								fbe_next    = 2'h3;
								fwdata_next = req_wdata_in[15:0];
								state_next  = ST_FLASH_HI;
							end else begin
								fhaddr_next = dif.off[15:1]; // one edge per halfword
								fbe_next    = req_addr_in[1] ? be_w[3:2] : be_w[1:0];
								fwdata_next = req_addr_in[1] ? req_wdata_in[31:16]
								                             : req_wdata_in[15:0];
							end
						end
						mmd_pkg::RT_AHB: ahb_next = 1'h1;
						mmd_pkg::RT_APB: begin
							apb_next = 1'h1;
							cnt_next = 1'(mmd_pkg::APB_CYC - 1);
						end
						mmd_pkg::RT_REMAP: cnt_next = 1'(mmd_pkg::APB_CYC - 1);
						// empty register space keeps slow bus timing, no select
						mmd_pkg::RT_PHOLE: cnt_next = 1'(mmd_pkg::APB_CYC - 1);
						default: cnt_next = 1'h0;
					endcase
				end
			end
			ST_FLASH_HI: begin
				lo_next     = flash_rdata_in;
				fhaddr_next = {fhaddr_reg[14:1], 1'h1};
				fbe_next    = 2'h3;
				fwdata_next = wdata_reg[31:16];
				state_next  = ST_WAIT;
			end
			ST_WAIT: begin
				if (cnt_reg) begin
					cnt_next = 1'h0;
				end else begin
					ack_next   = 1'h1;
					ready_next = 1'h1;
					fsel_next  = 1'h0;
					ssel_next  = 1'h0;
					ahb_next   = 1'h0;
					apb_next   = 1'h0;
					state_next = ST_IDLE;
					err_next   = route_reg == mmd_pkg::RT_HOLE;
					rdata_next = 32'h0;
					if (!write_reg) begin
						case (route_reg)
							mmd_pkg::RT_SRAM:  rdata_next = sram_rdata_in;
							mmd_pkg::RT_FLASH: rdata_next = word_reg
								? {flash_rdata_in, lo_reg}
								: {flash_rdata_in, flash_rdata_in};
							mmd_pkg::RT_AHB:   rdata_next = ahb_rdata_in;
							mmd_pkg::RT_APB:   rdata_next = apb_rdata_in;
							mmd_pkg::RT_REMAP: rdata_next = {31'h0, remap_reg};
							default:           rdata_next = 32'h0;
						endcase
					end else if (route_reg == mmd_pkg::RT_REMAP && be_reg[0]) begin
						remap_next = wdata_reg[mmd_pkg::REMAP_BIT];
					end
				end
			end
			default: state_next = ST_IDLE;
		endcase
	end

	// registers only; a low clock enable freezes everything except the synchronous reset, which still acts
	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			state_reg  <= ST_IDLE;
			cnt_reg    <= 1'h0;
			route_reg  <= mmd_pkg::RT_HOLE;
			word_reg   <= 1'h0;
			lo_reg     <= 16'h0;
			remap_reg  <= mmd_pkg::REMAP_RST;
			ready_reg  <= 1'h1;
			ack_reg    <= 1'h0;
			err_reg    <= 1'h0;
			rdata_reg  <= 32'h0;
			fsel_reg   <= 1'h0;
			fbank_reg  <= 1'h0;
			fhaddr_reg <= 15'h0;
			fbe_reg    <= 2'h0;
			fwdata_reg <= 16'h0;
			ssel_reg   <= 1'h0;
			saddr_reg  <= 11'h0;
			ahb_reg    <= 1'h0;
			apb_reg    <= 1'h0;
			paddr_reg  <= 16'h0;
			write_reg  <= 1'h0;
			be_reg     <= 4'h0;
			wdata_reg  <= 32'h0;
		end else if (ce_in) begin
			state_reg  <= state_next;
			cnt_reg    <= cnt_next;
			route_reg  <= route_next;
			word_reg   <= word_next;
			lo_reg     <= lo_next;
			remap_reg  <= remap_next;
			ready_reg  <= ready_next;
			ack_reg    <= ack_next;
			err_reg    <= err_next;
			rdata_reg  <= rdata_next;
			fsel_reg   <= fsel_next;
			fbank_reg  <= fbank_next;
			fhaddr_reg <= fhaddr_next;
			fbe_reg    <= fbe_next;
			fwdata_reg <= fwdata_next;
			ssel_reg   <= ssel_next;
			saddr_reg  <= saddr_next;
			ahb_reg    <= ahb_next;
			apb_reg    <= apb_next;
			paddr_reg  <= paddr_next;
			write_reg  <= write_next;
			be_reg     <= be_next;
			wdata_reg  <= wdata_next;
		end
	end

	// outputs straight from their flops
	assign req_ready_out   = ready_reg;
	assign rsp_ack_out     = ack_reg;
	assign rsp_err_out     = err_reg;
	assign rsp_rdata_out   = rdata_reg;
	assign remap_out       = remap_reg;
	assign flash_sel_out   = fsel_reg;
	assign flash_bank_out  = fbank_reg;
	assign flash_haddr_out = fhaddr_reg;
	assign flash_page_out  = fhaddr_reg[14:mmd_pkg::PAGE_HW_LSB];
	assign flash_be_out    = fbe_reg;
	assign flash_wdata_out = fwdata_reg;
	assign sram_sel_out    = ssel_reg;
	assign sram_addr_out   = saddr_reg;
	assign ahb_sel_out     = ahb_reg;
	assign apb_sel_out     = apb_reg;
	assign per_addr_out    = paddr_reg;
	assign tgt_write_out   = write_reg;
	assign tgt_be_out      = be_reg;
	assign tgt_wdata_out   = wdata_reg;

	// checks; they assume software keeps off empty register space only loosely
	localparam int FMAX = mmd_pkg::FLASH_MAX_CYC;
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_b_in);
	logic take_fw, take_fh, take_ahb, take_apb;
	assign take_fw  = take_w && dif.route == mmd_pkg::RT_FLASH
	                  && req_size_in == mmd_pkg::SZ_WORD && !req_write_in;
	assign take_fh  = take_w && dif.route == mmd_pkg::RT_FLASH
	                  && req_size_in != mmd_pkg::SZ_WORD;
	assign take_ahb = take_w && dif.route == mmd_pkg::RT_AHB;
	assign take_apb = take_w && dif.route == mmd_pkg::RT_APB;

	AST_RESET_FLASH: assert property ($rose(rst_b_in) |-> remap_out)
		else $error("flash not at zero after reset");
	AST_ZERO_FLASH: assert property (remap_out && req_addr_in < 32'h0000_1000
		&& !req_write_in |-> dif.route == mmd_pkg::RT_FLASH)
		else $error("zero region not flash");
	AST_ZERO_SRAM: assert property (!remap_out && req_addr_in < 32'h0000_1000
		|-> dif.route == mmd_pkg::RT_SRAM)
		else $error("zero region not sram after remap");
	AST_REMAP_CLR: assert property (take_w && dif.route == mmd_pkg::RT_REMAP
		&& req_write_in && be_w[0] && !req_wdata_in[0] ##1 ce_in ##1 ce_in
		|=> !remap_out)
		else $error("remap bit not cleared");
	AST_WORD_HALVES: assert property (take_fw ##1 ce_in |-> (flash_sel_out
		&& !flash_haddr_out[0]) ##1 (flash_sel_out && flash_haddr_out[0]))
		else $error("word fetch not two halfwords");
	AST_WORD_ORDER: assert property (take_fw ##1 ce_in ##1 ce_in
		|=> rsp_ack_out && rsp_rdata_out[15:0] == $past(flash_rdata_in, 2)
		&& rsp_rdata_out[31:16] == $past(flash_rdata_in))
		else $error("flash word lanes wrong");
	AST_FLASH_RATE: assert property (take_fh |-> ##[1:FMAX] rsp_ack_out)
		else $error("flash halfword too slow");
	AST_BANK0: assert property (req_addr_in >= mmd_pkg::FLASH0_BASE
		&& req_addr_in < mmd_pkg::FLASH0_USER |-> dif.route == mmd_pkg::RT_FLASH
		&& dif.off[16])
		else $error("bank 0 decode wrong");
	AST_BANK1: assert property (req_addr_in >= mmd_pkg::FLASH1_BASE
		&& req_addr_in < mmd_pkg::FLASH0_BASE |-> dif.route == mmd_pkg::RT_FLASH
		&& !dif.off[16])
		else $error("bank 1 decode wrong");
	// page index must follow the byte offset in 512-byte steps, not just mirror haddr
	AST_PAGE: assert property (take_w && dif.route == mmd_pkg::RT_FLASH
		|=> flash_page_out == $past(dif.off[15:9]))
		else $error("page index wrong");
	AST_SRAM_ONE: assert property (take_w && dif.route == mmd_pkg::RT_SRAM
		&& !req_write_in ##1 ce_in |-> sram_sel_out
		##1 (rsp_ack_out && rsp_rdata_out == $past(sram_rdata_in)))
		else $error("sram read not single access");
	AST_PER_SPACE: assert property (req_addr_in[31:16] != 16'hffff
		|-> dif.route != mmd_pkg::RT_APB && dif.route != mmd_pkg::RT_AHB)
		else $error("register route outside top pages");
	AST_AHB_ONE: assert property (take_ahb ##1 ce_in |=> rsp_ack_out)
		else $error("fast bus not one cycle");
	AST_APB_TWO: assert property (take_apb ##1 ce_in ##1 ce_in
		|-> !rsp_ack_out ##1 rsp_ack_out)
		else $error("slow bus not two cycles");
	AST_GPIO_AHB: assert property (req_addr_in[31:8] == 24'hffff0d
		&& req_addr_in[7:5] < 3'h3 |-> dif.route == mmd_pkg::RT_AHB)
		else $error("gpio not on fast bus");
	AST_IRQ_APB: assert property (req_addr_in[31:8] == 24'hffff00
		|-> dif.route == mmd_pkg::RT_APB)
		else $error("interrupt block not decoded");
	AST_SYSCTL: assert property (req_addr_in[31:2] == 30'h3fffc088
		|-> dif.route == mmd_pkg::RT_REMAP)
		else $error("remap register not decoded");
	AST_EMPTY_ZERO: assert property (take_w && dif.route == mmd_pkg::RT_PHOLE
		##1 ce_in ##1 ce_in |=> rsp_ack_out && rsp_rdata_out == 32'h0
		&& !rsp_err_out)
		else $error("empty register space not zero");

	COV_FLASH_WORD: cover property (take_fw ##[1:4] rsp_ack_out);
	COV_APB: cover property (take_apb ##[1:4] rsp_ack_out);
	COV_REMAP: cover property (remap_out ##[1:20] !remap_out);
	COV_SRAM_ZERO: cover property (take_w && !remap_out && req_addr_in == 32'h0);
endmodule // mmd_memory_map_decoder
`default_nettype wire

/* File: verification/mmd_tgt_model.sv */
// mmd_tgt_model: flash, sram and register-bus targets that answer the decoder
// assumes: each answer is combinational while its select is high
`timescale 1ns/1ps
`default_nettype none
module mmd_tgt_model (
	input  wire logic        flash_sel_in,
	input  wire logic        flash_bank_in,
	input  wire logic [14:0] flash_haddr_in,
	output logic [15:0]      flash_rdata_out,
	input  wire logic        sram_sel_in,
	input  wire logic [10:0] sram_addr_in,
	output logic [31:0]      sram_rdata_out,
	input  wire logic        ahb_sel_in,
	input  wire logic        apb_sel_in,
	input  wire logic [15:0] per_addr_in,
	output logic [31:0]      ahb_rdata_out,
	output logic [31:0]      apb_rdata_out
);
	logic [15:0] fv; // halfword stored at this flash location
	logic [31:0] sv; // word stored at this sram location
	logic [31:0] av; // fast-bus register contents
	logic [31:0] pv; // slow-bus register contents
	// data is a fixed function of the location, so the bench can predict it;
	// an unselected target shows the inverse, never a stale valid-looking value
	always_comb begin
		fv = {flash_bank_in, flash_haddr_in};                  // 16-bit path
		sv = {5'h0c, sram_addr_in, 5'h13, sram_addr_in};       // full width
		av = {16'ha1b0, per_addr_in};
		pv = {16'hb2c0, per_addr_in};
		flash_rdata_out = flash_sel_in ? fv : ~fv;
		sram_rdata_out  = sram_sel_in ? sv : ~sv;
		ahb_rdata_out   = ahb_sel_in ? av : ~av;
		apb_rdata_out   = apb_sel_in ? pv : ~pv;
	end
endmodule // mmd_tgt_model
`default_nettype wire

/* File: verification/test_memory_map_decoder.sv */
// test_memory_map_decoder: directed scenarios for the memory map decoder
// assumes: mmd_tgt_model answers every target, one 125 MHz clock
`timescale 1ns/1ps
`default_nettype none
module test_memory_map_decoder;
	logic        clk_sys_in = 1'h0; // 8 ns period
	logic        rst_b      = 1'h0; // active low, synchronous
	logic        ce         = 1'h1; // clock enable
	logic        valid      = 1'h0; // request strobe
	logic [31:0] addr       = 32'h0;
	logic        wr         = 1'h0;
	logic [1:0]  size       = 2'h0;
	logic [31:0] wdata      = 32'h0;
	logic        ready, ack, err, remap, fsel, fbank, ssel, asel, psel, twr;
	logic [14:0] fhaddr;
	logic [6:0]  fpage;
	logic [1:0]  fbe;
	logic [15:0] fwd, frd, paddr;
	logic [10:0] saddr;
	logic [31:0] rdata, srd, ard, prd, twd;
	logic [3:0]  tbe;
	// captures one and two edges after the take, and the outcome of the access
	logic        c_fsel, c_fbank, c_ssel, c_asel, c_psel, er;
	logic [14:0] c_h0, c_h1;
	logic [18:0] c_fw0;      // flash lanes, data and write flag, first half
	logic [17:0] c_fw1;      // flash lanes and data, second half
	logic [6:0]  c_page;
	logic [10:0] c_saddr;
	logic [3:0]  c_be;
	logic [31:0] c_wd, rd;
	int          n, err_count = 0, check_count = 0;
	mmd_memory_map_decoder dut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b), .ce_in(ce),
		.req_valid_in(valid), .req_addr_in(addr), .req_write_in(wr), .req_size_in(size),
		.req_wdata_in(wdata), .req_ready_out(ready), .rsp_ack_out(ack), .rsp_err_out(err),
		.rsp_rdata_out(rdata), .remap_out(remap), .flash_sel_out(fsel),
		.flash_bank_out(fbank), .flash_haddr_out(fhaddr), .flash_page_out(fpage),
		.flash_be_out(fbe), .flash_wdata_out(fwd), .flash_rdata_in(frd),
		.sram_sel_out(ssel), .sram_addr_out(saddr), .sram_rdata_in(srd),
		.ahb_sel_out(asel), .apb_sel_out(psel), .per_addr_out(paddr),
		.ahb_rdata_in(ard), .apb_rdata_in(prd), .tgt_write_out(twr),
		.tgt_be_out(tbe), .tgt_wdata_out(twd));
	mmd_tgt_model tgt (.flash_sel_in(fsel), .flash_bank_in(fbank), .flash_haddr_in(fhaddr),
		.flash_rdata_out(frd), .sram_sel_in(ssel), .sram_addr_in(saddr),
		.sram_rdata_out(srd), .ahb_sel_in(asel), .apb_sel_in(psel), .per_addr_in(paddr),
		.ahb_rdata_out(ard), .apb_rdata_out(prd));
	// free-running system clock
	initial begin
		forever #4 clk_sys_in = ~clk_sys_in;
	end
	function automatic logic [15:0] fv(logic b, logic [14:0] h);
		return {b, h};
	endfunction
	function automatic logic [31:0] sv(logic [10:0] a);
		return {5'h0c, a, 5'h13, a};
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// one access: hold the request until taken, then count edges to the ack
	task automatic acc(input logic [31:0] a, input logic w, input logic [1:0] sz,
		input logic [31:0] d);
		int i;
		i = 0;
		@(posedge clk_sys_in);
		valid <= 1'h1;
		addr  <= a;
		wr    <= w;
		size  <= sz;
		wdata <= d;
		@(negedge clk_sys_in);
		while (ready !== 1'b1 && i < 20) begin
			@(negedge clk_sys_in);
			i++;
		end
		@(posedge clk_sys_in);
		valid <= 1'h0;
		n = 0;
		do begin
			@(negedge clk_sys_in);
			n++;
			if (n == 1) begin
				{c_fsel, c_fbank, c_h0, c_page} = {fsel, fbank, fhaddr, fpage};
				{c_ssel, c_saddr, c_asel, c_psel, c_be, c_wd} = {ssel, saddr, asel, psel, tbe, twd};
				c_fw0 = {fbe, fwd, twr};
			end
			if (n == 2) begin
				c_h1  = fhaddr;
				c_fw1 = {fbe, fwd};
			end
		end while (ack !== 1'b1 && n < 20);
		// a hung handshake counts against the run, not just a bad capture
		if (ack !== 1'b1 || i == 20)
			err_count++;
		n  = n - 1; // enabled edges from take to ack
		rd = rdata;
		er = err;
	endtask
	task automatic t_reset;
		chk(remap, 1); // flash at zero
		chk({fsel, ssel, asel, psel, ready}, 1);
	endtask
	task automatic t_flash;
		acc(32'h0, 0, mmd_pkg::SZ_WORD, 0);
		chk({c_fsel, c_fbank}, 3); // alias reaches bank 1
		chk({c_h0, c_h1}, 1); // low half first
		chk(rd, {fv(1, 1), fv(1, 0)}); // byte order
		chk(n, 2); // two halfword accesses
		acc(32'h0008_0004, 0, mmd_pkg::SZ_WORD, 0);
		chk(rd, {fv(1, 3), fv(1, 2)}); // word split
		acc(32'h0009_0200, 0, mmd_pkg::SZ_HALF, 0);
		chk({c_fbank, c_h0}, 16'h0100); // bank 0, halfword 0x100
		chk(c_page, 1); // 512-byte page
		chk(rd, {fv(0, 15'h100), fv(0, 15'h100)});
		chk(n <= mmd_pkg::FLASH_MAX_CYC, 1); // halfword rate
		acc(32'h0008_fffe, 0, mmd_pkg::SZ_HALF, 0);
		chk({c_fbank, c_h0, c_page}, {1'h1, 15'h7fff, 7'h7f}); // bank 1 top
		acc(32'h0009_f6fe, 0, mmd_pkg::SZ_HALF, 0);
		chk({er, c_h0}, 15'h7b7f); // last user halfword
		acc(32'h0009_f700, 1, mmd_pkg::SZ_HALF, 32'h1234);
		chk({er, c_fsel, n[3:0]}, 6'h21); // boot page write refused
		acc(32'h0008_0010, 1, mmd_pkg::SZ_WORD, 32'hcafe_f00d);
		chk({c_h0, c_h1}, {15'h8, 15'h9}); // even then odd halfword
		chk(c_fw0, {2'h3, 16'hf00d, 1'h1}); // low half written first
		chk(c_fw1, {2'h3, 16'hcafe}); // then the high half
	endtask
	task automatic t_sram;
		// clock enable low: a pending request must not be taken
		@(posedge clk_sys_in);
		ce    <= 1'h0;
		valid <= 1'h1;
		addr  <= mmd_pkg::SRAM_BASE;
		wr    <= 1'h0;
		size  <= mmd_pkg::SZ_WORD;
		@(posedge clk_sys_in);
		@(negedge clk_sys_in);
		chk({ready, ssel, ack}, 3'h4); // frozen edges do not count
		@(posedge clk_sys_in);
		valid <= 1'h0;
		ce    <= 1'h1;
		acc(mmd_pkg::SRAM_BASE + 32'h1ffc, 0, mmd_pkg::SZ_WORD, 0);
		chk({c_ssel, c_saddr, n[3:0]}, {1'h1, 11'h7ff, 4'h1}); // single access
		chk(rd, sv(11'h7ff)); // full width
		acc(mmd_pkg::SRAM_BASE + 32'h2000, 0, mmd_pkg::SZ_WORD, 0);
		chk({er, c_ssel}, 2); // past 2k words
		acc(mmd_pkg::SRAM_BASE + 32'h6, 1, mmd_pkg::SZ_BYTE, 32'h00ab_0000);
		chk({c_be, c_wd[23:16], c_saddr}, {4'h4, 8'hab, 11'h1}); // byte lane
		acc(mmd_pkg::SRAM_BASE + 32'h2, 1, mmd_pkg::SZ_HALF, 32'hbeef_0000);
		chk({c_be, c_wd[31:16]}, {4'hc, 16'hbeef}); // upper half lanes
	endtask
	// fast bus, slow bus and empty register space reads, then a write to empty register space
	task automatic t_regs;
		logic [31:0] ra [6];
		int          rk [6];
		ra = '{32'hffff_0d00, 32'hffff_0e80, 32'hffff_0000, 32'hffff_0300,
			32'hffff_0230, 32'hffff_0f00};
		rk = '{0, 0, 1, 1, 1, 2}; // empty space touched only to prove it inert
		for (int i = 0; i < 7; i++) begin
			acc(i < 6 ? ra[i] : 32'hffff_1000, i == 6, mmd_pkg::SZ_WORD, 32'h5);
			if (i == 6) begin
				chk({c_asel, c_psel, er, n[3:0]}, 2); // empty write ignored
			end else if (rk[i] == 0) begin
				chk({c_asel, c_psel, n[3:0]}, 6'h21); // one cycle
				chk(rd, {16'ha1b0, ra[i][15:0]});
			end else if (rk[i] == 1) begin
				chk({c_asel, c_psel, n[3:0]}, 6'h12); // two cycles
				chk(rd, {16'hb2c0, ra[i][15:0]});
			end else begin
				chk({c_asel, c_psel, er, n[3:0]}, 2); // empty reads zero
				chk(rd, 0); // no data
			end
		end
	endtask
	task automatic t_remap;
		acc(mmd_pkg::REMAP_ADDR, 1, mmd_pkg::SZ_BYTE, 0);
		chk({remap, n[3:0]}, 2); // bit cleared
		acc(32'h0, 0, mmd_pkg::SZ_WORD, 0);
		chk({c_ssel, c_fsel, c_saddr}, 13'h1000); // sram at zero
		chk(rd, sv(0)); // sram data
		acc(32'h2000, 0, mmd_pkg::SZ_WORD, 0);
		chk(er, 1); // beyond sram alias
		@(posedge clk_sys_in);
		rst_b <= 1'h0;
		@(posedge clk_sys_in);
		rst_b <= 1'h1;
		@(negedge clk_sys_in);
		chk(remap, 1); // any reset restores flash
		acc(32'h0, 0, mmd_pkg::SZ_HALF, 0);
		chk({c_fsel, c_fbank, c_h0}, 17'h18000); // flash back at zero
	endtask
	// watchdog: the whole sequence needs well under 1000 cycles
	initial begin
		#20000;
		err_count++;
		test_done();
	end
	// main sequence
	initial begin
		repeat (8) @(posedge clk_sys_in);
		rst_b <= 1'h1;
		@(negedge clk_sys_in);
		t_reset();
		t_flash();
		t_sram();
		t_regs();
		t_remap();
		test_done();
	end
endmodule // test_memory_map_decoder
`default_nettype wire
